// file: core/watchdog_timer.v
// Purpose: 16-bit fail-safe watchdog with reload and reset-out
// Assumes: command strobes are one-cycle pulses from the same clock
// Notes:   overflow raises an internal reset pulse and pulls reset out low
`timescale 1ns/1ps
`include "watchdog_map.vh"
// Behaviour
// - After every reset the watchdog counter is enabled and running.
// - A disable request works only before end of initialization has executed.
// - Counter overflow triggers an internal reset and drives the reset-out pin low.
// - The watchdog is a sixteen-bit up counter.
// - The counter advances on the system clock divided by 2 or by 128 as software chooses.
// - Each service loads the counter upper byte from the reload value.
// - The default interval after reset is a full count at divide by 2, about 5.24 ms.
// - Reload and prescaler choices span intervals from about 20 us to about 336 ms.
// - End of initialization signals completion on the reset-out pin and closes the disable window.
module watchdog_timer #(
	parameter CNT_W     = `WD_CNT_W,
	parameter RESET_OUT_PIN_CY = `WD_RESET_OUT_PIN_CYC
) (
	// Clock and reset
	input  wire                    clk,
	input  wire                    rst_b,
	// CPU command strobes
	input  wire                    service,
	input  wire                    disable_req,
	input  wire                    end_of_init_instruction,
	// Configuration from software
	input  wire                    reload_we,
	input  wire [`WD_RELOAD_W-1:0] reload_data,
	input  wire                    prescale_slow,
	// Status and reset outputs
	output reg  [CNT_W-1:0]        count,
	output reg                     running,
	output reg                     init_done,
	output reg                     wd_reset,
	output reg                     reset_out_pin_b
);
	// Hold preset, cut to the width of the hold counter
	localparam [2:0]       HOLD_INIT = RESET_OUT_PIN_CY[2:0];
	// Counter step of one at the counter width
	localparam [CNT_W-1:0] CNT_ONE   = {{(CNT_W-1){1'b0}}, 1'b1};

	// Stored state
	reg  [`WD_RELOAD_W-1:0] wd_reload_value;
	reg  [2:0]              hold;

	// Next values
	reg  [`WD_RELOAD_W-1:0] next_reload;
	reg  [CNT_W-1:0]        next_count;
	reg                     next_running;
	reg                     next_init_done;
	reg                     next_wd_reset;
	reg  [2:0]              next_hold;
	reg                     next_pin_b;

	// Internal events
	wire                    tick;
	wire                    ovf;
	wire                    dis_allowed;
	wire                    hold_active;
	wire                    init_seen;

	// Decode helpers

	// True when the counter sits at its last value
	function at_top;
		input [CNT_W-1:0] value;
		begin
			at_top = &value;
		end
	endfunction

	// True while an overflow hold is still counting down
	function hold_busy;
		input [2:0] left;
		begin
			hold_busy = (left != 3'h0);
		end
	endfunction

	// Service image: reload in the high byte, low byte cleared
	function [CNT_W-1:0] service_image;
		input [`WD_RELOAD_W-1:0] rel;
		begin
			service_image = {rel, {(CNT_W-`WD_RELOAD_W){1'b0}}};
		end
	endfunction

	// Prescaler tick, restarted by every service
	wd_prescaler u_pre (
		.clk     (clk),
		.rst_b   (rst_b),
		.slow    (prescale_slow),
		.restart (service),
		.tick    (tick)
	);

	// Overflow: last count value meets a tick while enabled
	assign ovf         = running & tick & at_top(count);
	// Disable window closes at end of init, its own cycle included
	assign dis_allowed = disable_req & ~init_done & ~end_of_init_instruction;
	// Overflow hold still counting down
	assign hold_active = hold_busy(hold);
	// End of init now or earlier
	assign init_seen   = end_of_init_instruction | init_done;

	// Reload field next value
	always @* begin
		next_reload = wd_reload_value;
		if (reload_we) begin
			next_reload = reload_data;
		end
	end

	// Enable next value, cleared only inside the disable window
	always @* begin
		next_running = running;
		if (dis_allowed) begin
			next_running = 1'b0;
		end
	end

	// Init-done next value, set once by end of init
	always @* begin
		next_init_done = init_done;
		if (end_of_init_instruction) begin
			next_init_done = 1'b1;
		end
	end

	// Counter next value, service wins over a tick
	always @* begin
		next_count = count;
		if (service) begin
			next_count = service_image(wd_reload_value);
		end else if (running && tick) begin
			next_count = count + CNT_ONE;
		end
	end

	// Overflow pulse length and hold countdown
	always @* begin
		next_wd_reset = wd_reset;
		next_hold     = hold;
		if (ovf) begin
			next_wd_reset = 1'b1;
			next_hold     = HOLD_INIT;
		end else if (hold_active) begin
			next_hold = hold - 3'h1;
		end else begin
			next_wd_reset = 1'b0;
		end
	end

	// Reset-out level: low in overflow hold, released after end of init
	always @* begin
		next_pin_b = reset_out_pin_b;
		if (ovf || hold_active) begin
			next_pin_b = 1'b0;
		end else if (init_seen) begin
			next_pin_b = 1'b1;
		end
	end

	// Registers

	// Reload field register
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_reload_value <= `WD_RELOAD_RST;
		end else begin
			wd_reload_value <= next_reload;
		end
	end

	// Enable register, running out of every reset
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			running <= 1'b1;
		end else begin
			running <= next_running;
		end
	end

	// Init-done register
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			init_done <= 1'b0;
		end else begin
			init_done <= next_init_done;
		end
	end

	// Counter register, full count from zero after reset
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= `WD_CNT_RST;
		end else begin
			count <= next_count;
		end
	end

	// Overflow pulse and hold registers
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_reset <= 1'b0;
			hold     <= 3'h0;
		end else begin
			wd_reset <= next_wd_reset;
			hold     <= next_hold;
		end
	end

	// Reset-out register, low from reset until end of init
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reset_out_pin_b <= 1'b0;
		end else begin
			reset_out_pin_b <= next_pin_b;
		end
	end
endmodule

// file: core/watchdog_map.vh
// Purpose: constants for the watchdog timer
// Assumes: 25 MHz system clock
// Notes:   all figures as macros
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH
`define WD_CNT_W         16
`define WD_RELOAD_W      8
`define WD_RELOAD_RST    8'h00
`define WD_CNT_RST       16'h0000
`define WD_DIV_SLOW      7'h7f
`define WD_DIV_FAST      7'h01
`define WD_CLK_MHZ       25
`define WD_DEFAULT_US    5240
`define WD_RESET_OUT_PIN_CYC    4
`endif

// file: core/wd_prescaler.v
// Purpose: divide-by-2 or divide-by-128 tick generator
// Assumes: one system clock
// Notes:   tick is one cycle wide
`timescale 1ns/1ps
`include "watchdog_map.vh"
module wd_prescaler (
	// Clock and reset
	input  wire clk,
	input  wire rst_b,
	// Control
	input  wire slow,
	input  wire restart,
	// Output
	output reg  tick
);
	reg [6:0] div;

	// Free divider, terminal count chosen by slow
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div  <= 7'h00;
			tick <= 1'b0;
		end else if (restart) begin
			div  <= 7'h00;
			tick <= 1'b0;
		end else if (div == (slow ? `WD_DIV_SLOW : `WD_DIV_FAST)) begin
			div  <= 7'h00;
			tick <= 1'b1;
		end else begin
			div  <= div + 7'h01;
			tick <= 1'b0;
		end
	end
endmodule

// file: verif/watchdog_timer_assertions.sv
// Purpose: port checks for the watchdog timer
// Assumes: default reset-out hold of five cycles
// Notes:   bound into every watchdog_timer
`timescale 1ns/1ps
module wd_chk (
	// Clock and reset
	input wire        clk,
	input wire        rst_b,
	// Strobes
	input wire        service,
	input wire        disable_req,
	input wire        end_of_init_instruction,
	// Outputs watched
	input wire        running,
	input wire        init_done,
	input wire        wd_reset,
	input wire        reset_out_pin_b,
	input wire [15:0] count
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_svc_low: assert property (service |=> count[7:0] == 8'h00) else $error("low byte");
	chk_first_run: assert property ($rose(rst_b) |-> running) else $error("idle");
	chk_ovf_pin: assert property ($rose(wd_reset) |-> !reset_out_pin_b) else $error("pin");
	chk_ovf_full: assert property ($rose(wd_reset) |-> $past(count) == 16'hffff) else $error("early");
	chk_ovf_hold: assert property ($rose(wd_reset) |-> wd_reset[*5]) else $error("short");
	chk_count_step: assert property ($changed(count) && !$past(service) |->
		count - $past(count) == 16'h1) else $error("step");
	chk_dis_lock: assert property (init_done && disable_req && running |=> running)
		else $error("lock");
	chk_dis_early: assert property (!init_done && !end_of_init_instruction && disable_req
		|=> !running) else $error("dis");
	chk_init_pin: assert property (end_of_init_instruction && !wd_reset && count != 16'hffff
		|=> init_done && reset_out_pin_b) else $error("init");
	// Main scenarios reached
	cover property (service);
	cover property ($rose(wd_reset));
	cover property (init_done && disable_req);
endmodule
bind watchdog_timer wd_chk wd_chk_inst (.clk, .rst_b, .service, .disable_req,
	.end_of_init_instruction, .running, .init_done, .wd_reset, .reset_out_pin_b, .count);

// file: verif/tb.sv
// Purpose: self-checking bench for watchdog_timer
// Assumes: 25 MHz clock
// Notes:   strobes change at falling edge
`timescale 1ns/1ps
module tb;
	reg clk = 0, rst_b = 0, prescale_slow = 0;
	reg [3:0] st = 0;
	reg [7:0] reload_data = 8'hff;
	wire [15:0] count;
	wire running, init_done, wd_reset, reset_out_pin_b;
	int n_errors = 0, comparisons = 0, n;
	always #20 clk = ~clk;
	watchdog_timer watchdog_timer_inst (.clk, .rst_b, .service(st[0]), .disable_req(st[1]),
		.end_of_init_instruction(st[2]), .reload_we(st[3]), .reload_data,
		.prescale_slow, .count, .running, .init_done, .wd_reset, .reset_out_pin_b);
	task chk(string s, logic [15:0] v, e);
		comparisons++;
		if (v !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", s, e, v);
		end
	endtask
	task stop_test;
		if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task go(logic [3:0] k);
		@(negedge clk) st = k;
		@(negedge clk) st = 0;
	endtask
	task rst;
		rst_b = 0;
		prescale_slow = 0;
		repeat (16) @(negedge clk);
		rst_b = 1;
	endtask
	task t_fast;
		rst;
		chk("run", running, 1);
		go(1);
		chk("rel0", count, 0);
		go(8);
		go(1);
		chk("load", count, 16'hff00);
		for (n = 0; !wd_reset && n < 900; n++) @(negedge clk);
		chk("span", n > 500 && n < 520, 1);
		chk("pin", reset_out_pin_b, 0);
	endtask
	task t_init;
		rst;
		go(2);
		chk("dis", running, 0);
		rst;
		go(4);
		chk("init", {init_done, reset_out_pin_b}, 3);
		go(2);
		chk("lock", running, 1);
	endtask
	task t_slow;
		rst;
		prescale_slow = 1;
		reload_data = 8'h80;
		go(8);
		go(1);
		repeat (1280) @(negedge clk);
		chk("slow", count, 16'h8009);
		chk("ovf", wd_reset, 0);
	endtask
	initial begin
		t_fast;
		t_init;
		t_slow;
		stop_test;
	end
	initial begin
		#200000;
		n_errors++;
		stop_test;
	end
endmodule
